// ==== rtl/pfz_core.sv ====
// power-up reset and pin-controlled freeze for the registered outputs
// assumes arst_n models supply-ramp detection; no other reset exists
// assumes core logic arrives as next-state values at logic_d
`timescale 1ns/10ps
module pfz_core
    import pfz_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // configuration
    input wire logic freeze_option_en,
    // pins from the board
    input wire logic freeze_request_pin,
    input wire logic oe_pin,
    input wire logic [WIDTH-1:0] logic_d,
    // outputs
    output logic [WIDTH-1:0] reg_out,
    output logic [WIDTH-1:0] reg_out_oe,
    output logic shared_pin_data,
    output logic frozen,
    output logic settled
);
    logic req_lvl, oe_lvl;
    logic [WIDTH-1:0] d_lvl;
    pfz_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [WIDTH-1:0] q_reg, q_next;
    logic [WIDTH-1:0] oe_reg, oe_next;
    logic shared_reg, shared_next;
    logic frozen_reg, frozen_next;
    logic settled_reg, settled_next;
    logic freeze_req;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    pfz_sync u_sync_req (.ref_clk(ref_clk), .arst_n(arst_n), .pin_in(freeze_request_pin), .level_out(req_lvl));
    pfz_sync u_sync_oe (.ref_clk(ref_clk), .arst_n(arst_n), .pin_in(oe_pin), .level_out(oe_lvl));
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_dsync
            pfz_sync u_sync_d (.ref_clk(ref_clk), .arst_n(arst_n), .pin_in(logic_d[gi]), .level_out(d_lvl[gi]));
        end
    endgenerate

    // option off means the pin is just another input and never freezes
    assign freeze_req = freeze_option_en & req_lvl;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        q_next = q_reg;
        oe_next = oe_reg;
        shared_next = shared_reg;
        settled_next = settled_reg;
        frozen_next = frozen_reg;
        unique case (state_reg)
            PFZ_SETTLE: begin
                // clock ignored until the settle interval ends
                cnt_next = cnt_reg + CNT_W'(1);
                if (cnt_reg == SETTLE_LAST) begin
                    state_next = PFZ_RUN;
                    settled_next = 1'b1;
                    cnt_next = '0;
                end
            end
            PFZ_RUN: begin
                if (freeze_req) begin
                    // level freeze: everything held from this edge onward
                    state_next = PFZ_FREEZE;
                    frozen_next = 1'b1;
                end else begin
                    q_next = d_lvl;
                    oe_next = {WIDTH{oe_lvl}};
                    shared_next = freeze_option_en ? 1'b0 : req_lvl;
                end
            end
            PFZ_FREEZE: begin
                // data, enables and the plain-input copy stay put
                if (!freeze_req) begin
                    state_next = PFZ_RUN;
                    frozen_next = 1'b0;
                end
            end
            default: begin
                state_next = PFZ_SETTLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= PFZ_SETTLE;
            cnt_reg <= '0;
            q_reg <= '0;
            oe_reg <= '0;
            shared_reg <= 1'b0;
            frozen_reg <= 1'b0;
            settled_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            q_reg <= q_next;
            oe_reg <= oe_next;
            shared_reg <= shared_next;
            frozen_reg <= frozen_next;
            settled_reg <= settled_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // reg_out drives the inverted data state, cleared q_reg reads high; reg_out_oe is not inverted
    logic [WIDTH-1:0] out_reg;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg <= '1;
        end else begin
            out_reg <= ~q_next;
        end
    end
    assign reg_out = out_reg;
    assign reg_out_oe = oe_reg;
    assign shared_pin_data = shared_reg;
    assign frozen = frozen_reg;
    assign settled = settled_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_settle_time;
        @(posedge ref_clk) disable iff (!arst_n)
        $rose(settled) |-> $past(cnt_reg) == SETTLE_LAST;
    endproperty
    a_settle_time: assert property (p_settle_time) else $error("settle too early");

    property p_reset_clear;
        @(posedge ref_clk) disable iff (!arst_n)
        !$past(arst_n) |-> q_reg == '0 && reg_out_oe == '0 && !frozen && !settled;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("register not cleared at power-up");

    property p_settle_hold;
        @(posedge ref_clk) disable iff (!arst_n)
        !settled |=> $stable(q_reg);
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("capture during settle");

    property p_high_after_reset;
        @(posedge ref_clk) disable iff (!arst_n)
        !settled |-> reg_out == '1;
    endproperty
    a_high_after_reset: assert property (p_high_after_reset) else $error("output not high at reset");

    property p_hold_data;
        @(posedge ref_clk) disable iff (!arst_n)
        frozen && $past(frozen) |-> $stable(reg_out);
    endproperty
    a_hold_data: assert property (p_hold_data) else $error("data moved in freeze");

    property p_hold_oe;
        @(posedge ref_clk) disable iff (!arst_n)
        frozen && $past(frozen) |-> $stable(reg_out_oe);
    endproperty
    a_hold_oe: assert property (p_hold_oe) else $error("enable moved in freeze");

    property p_ignore_inputs;
        @(posedge ref_clk) disable iff (!arst_n)
        state_reg == PFZ_FREEZE |=> $stable(q_reg) && $stable(shared_pin_data);
    endproperty
    a_ignore_inputs: assert property (p_ignore_inputs) else $error("state moved in freeze");

    property p_release;
        @(posedge ref_clk) disable iff (!arst_n)
        (frozen && !freeze_req) ##1 !freeze_req |-> !frozen ##1 reg_out_oe == {WIDTH{$past(oe_lvl)}};
    endproperty
    a_release: assert property (p_release) else $error("no resume after release");

    property p_option_off;
        @(posedge ref_clk) disable iff (!arst_n)
        !freeze_option_en |=> !frozen || $past(frozen);
    endproperty
    a_option_off: assert property (p_option_off) else $error("froze with option off");

    property p_plain_input;
        @(posedge ref_clk) disable iff (!arst_n)
        !freeze_option_en && settled && !frozen |=> shared_pin_data == $past(req_lvl);
    endproperty
    a_plain_input: assert property (p_plain_input) else $error("shared pin not passed as input");

    property p_level_freeze;
        @(posedge ref_clk) disable iff (!arst_n)
        settled && freeze_req |=> frozen;
    endproperty
    a_level_freeze: assert property (p_level_freeze) else $error("freeze not entered");

    property p_capture;
        @(posedge ref_clk) disable iff (!arst_n)
        settled && !frozen && !freeze_req |=> q_reg == $past(d_lvl);
    endproperty
    a_capture: assert property (p_capture) else $error("data not captured outside freeze");
endmodule : pfz_core

// ==== rtl/pfz_pkg.sv ====
// package for the power-up reset and freeze hold block
// assumes a single 10 MHz clock domain
package pfz_pkg;
    localparam int CLK_PERIOD_NS = 100;
    // reset settle interval, maximum figure
    localparam int RESET_SETTLE_NS = 1000;
    localparam int RESET_SETTLE_CYC = (RESET_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // release to valid clock and output enable, slow grade, a longest time
    localparam int RELEASE_VALID_NS = 30;
    localparam int RELEASE_VALID_CYC = (RELEASE_VALID_NS / CLK_PERIOD_NS) < 1 ? 1 : RELEASE_VALID_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] SETTLE_LAST = CNT_W'(RESET_SETTLE_CYC - 1);
    localparam logic SYNC_RESET_VAL = 1'b0;
    typedef enum logic [1:0] {
        PFZ_SETTLE = 2'b00,
        PFZ_RUN = 2'b01,
        PFZ_FREEZE = 2'b11
    } pfz_state_t;
endpackage : pfz_pkg

// ==== rtl/pfz_sync.sv ====
// three-stage synchroniser with agreement filter for one pin
// assumes the pin is asynchronous to ref_clk
`timescale 1ns/10ps
module pfz_sync
    import pfz_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // pin and result
    input wire logic pin_in,
    output logic level_out
);
    logic s1_reg, s2_reg, s3_reg, lvl_reg;
    logic lvl_next;

    // change accepted only once the second and third stages agree
    always_comb begin
        lvl_next = lvl_reg;
        if (s2_reg == s3_reg) begin
            lvl_next = s3_reg;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_reg <= SYNC_RESET_VAL;
            s2_reg <= SYNC_RESET_VAL;
            s3_reg <= SYNC_RESET_VAL;
            lvl_reg <= SYNC_RESET_VAL;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            lvl_reg <= lvl_next;
        end
    end

    assign level_out = lvl_reg;
endmodule : pfz_sync

// ==== verification/pfz_board.sv ====
// board-side model driving clock-domain pins of the freeze block
// assumes settled comes from the block and commands come from the bench
`timescale 1ns/10ps
module pfz_board #(
    parameter int W = 8
) (
    // clock and status
    input wire logic ref_clk,
    input wire logic settled,
    // commands from the bench
    input wire logic [W-1:0] cmd_d,
    input wire logic cmd_oe,
    input wire logic cmd_frz,
    // pins toward the block
    output logic [W-1:0] d_pin = '0,
    output logic oe_pin = 1'b0,
    output logic frz_pin = 1'b0
);
    // pins stay put until the settle interval is over
    always @(posedge ref_clk) begin
        if (settled) begin
            d_pin <= cmd_d;
            oe_pin <= cmd_oe;
        end
        // freeze rises only after data and enable stood a full cycle
        frz_pin <= cmd_frz && settled && (frz_pin || (d_pin == cmd_d && oe_pin == cmd_oe));
    end
endmodule : pfz_board

// ==== verification/tb_pld_powerup_reset_and_powerdown_hold.sv ====
// self-checking bench for the power-up reset and freeze block
// assumes the board model in pfz_board.sv
`timescale 1ns/10ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin miscompares++; \
    $display("wrong value %s exp %h got %h", n, e, a); end end
module tb_pld_powerup_reset_and_powerdown_hold;
    import pfz_pkg::*;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic opt = 1'b1;
    logic c_oe = 1'b0;
    logic c_frz = 1'b0;
    logic [7:0] c_d = 8'hFF;
    logic [7:0] d_pin, reg_out, reg_out_oe;
    logic oe_pin, frz_pin, shared_pin_data, frozen, settled;
    int miscompares = 0;
    int checks_done = 0;
    pfz_board #(.W(8)) board (.ref_clk(ref_clk), .settled(settled), .cmd_d(c_d), .cmd_oe(c_oe),
        .cmd_frz(c_frz), .d_pin(d_pin), .oe_pin(oe_pin), .frz_pin(frz_pin));
    pfz_core #(.WIDTH(8)) dut (.ref_clk(ref_clk), .arst_n(arst_n), .freeze_option_en(opt),
        .freeze_request_pin(frz_pin), .oe_pin(oe_pin), .logic_d(d_pin), .reg_out(reg_out),
        .reg_out_oe(reg_out_oe), .shared_pin_data(shared_pin_data), .frozen(frozen), .settled(settled));
    initial begin
        forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    end
    task cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    // bounded wait for the freeze flag, then a settling margin before outputs are trusted
    task wait_frz(input logic v);
        for (int i = 0; i < 20 && frozen !== v; i++) cyc(1);
        `CHK("frozen", v, frozen)
        cyc(2);
    endtask : wait_frz
    task drive(input logic [7:0] d, input logic oe, input logic frz);
        @(posedge ref_clk);
        c_d <= d;
        c_oe <= oe;
        c_frz <= frz;
    endtask : drive
    task finish_test;
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test
    task t_reset;
        cyc(7);
        `CHK("reg_out", 8'hFF, reg_out)
        `CHK("settled", 1'b0, settled)
        @(posedge ref_clk);
        arst_n <= 1'b1;
        cyc(10);
        `CHK("reg_out", 8'hFF, reg_out)
        `CHK("settled", 1'b0, settled)
        cyc(1);
        `CHK("settled", 1'b1, settled)
        $display("test reset done");
    endtask : t_reset
    task t_capture;
        drive(8'h5A, 1'b1, 1'b0);
        cyc(8);
        `CHK("reg_out", 8'hA5, reg_out)
        `CHK("reg_out_oe", 8'hFF, reg_out_oe)
        $display("test capture done");
    endtask : t_capture
    task t_freeze;
        drive(8'h5A, 1'b1, 1'b1);
        wait_frz(1'b1);
        drive(8'h0F, 1'b0, 1'b1);
        cyc(10);
        `CHK("reg_out", 8'hA5, reg_out)
        `CHK("reg_out_oe", 8'hFF, reg_out_oe)
        drive(8'h0F, 1'b0, 1'b0);
        wait_frz(1'b0);
        `CHK("reg_out", 8'hF0, reg_out)
        `CHK("reg_out_oe", 8'h00, reg_out_oe)
        $display("test freeze done");
    endtask : t_freeze
    task t_hiz;
        drive(8'h0F, 1'b0, 1'b1);
        wait_frz(1'b1);
        drive(8'h81, 1'b1, 1'b1);
        cyc(10);
        `CHK("reg_out_oe", 8'h00, reg_out_oe)
        `CHK("reg_out", 8'hF0, reg_out)
        drive(8'h81, 1'b1, 1'b0);
        wait_frz(1'b0);
        `CHK("reg_out_oe", 8'hFF, reg_out_oe)
        `CHK("reg_out", 8'h7E, reg_out)
        $display("test hiz done");
    endtask : t_hiz
    task t_option;
        @(posedge ref_clk);
        opt <= 1'b0;
        drive(8'h81, 1'b1, 1'b1);
        cyc(10);
        `CHK("frozen", 1'b0, frozen)
        `CHK("shared_pin_data", 1'b1, shared_pin_data)
        drive(8'h22, 1'b1, 1'b0);
        cyc(10);
        `CHK("reg_out", 8'hDD, reg_out)
        `CHK("shared_pin_data", 1'b0, shared_pin_data)
        $display("test option done");
    endtask : t_option
    // second power-up in mid-run, with outputs away from their reset values
    task t_repower;
        @(posedge ref_clk);
        arst_n <= 1'b0;
        cyc(1);
        `CHK("reg_out", 8'hFF, reg_out)
        `CHK("reg_out_oe", 8'h00, reg_out_oe)
        `CHK("settled", 1'b0, settled)
        cyc(7);
        @(posedge ref_clk);
        arst_n <= 1'b1;
        cyc(10);
        `CHK("reg_out", 8'hFF, reg_out)
        `CHK("settled", 1'b0, settled)
        cyc(1);
        `CHK("settled", 1'b1, settled)
        cyc(2);
        `CHK("reg_out", 8'hDD, reg_out)
        `CHK("reg_out_oe", 8'hFF, reg_out_oe)
        $display("test repower done");
    endtask : t_repower
    initial begin
        t_reset();
        t_capture();
        t_freeze();
        t_hiz();
        t_option();
        t_repower();
        finish_test();
    end
    // the tests need well under 400 cycles
    initial begin
        repeat (2000) @(posedge ref_clk);
        miscompares++;
        $display("watchdog expired");
        finish_test();
    end
endmodule : tb_pld_powerup_reset_and_powerdown_hold
